// ==== verilog/adc_ctrl_pkg.sv ====
// Purpose: shared constants and types for the converter control block
// Assumes: 32-bit AHB-Lite register bus, byte address = register index times four
// Notes: indices are word indices; the bus decodes haddr[9:2] against them
package adc_ctrl_pkg;
   // register indices
   localparam logic [7:0] IDX_PIN_SEL = 8'h08;
   localparam logic [7:0] IDX_CTRL = 8'h09;
   localparam logic [7:0] IDX_OFFSET = 8'h0A;
   localparam logic [7:0] IDX_RES_UPPER = 8'h0B;
   localparam logic [7:0] IDX_RES_HIGH = 8'h0C;
   localparam logic [7:0] IDX_RES_LOW = 8'h0D;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h11;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h12;
   // control register fields
   localparam int CTRL_REF_BIT = 7;
   localparam int CTRL_CLK_HI = 6;
   localparam int CTRL_CLK_LO = 5;
   localparam int CTRL_RUN_BIT = 4;
   localparam int CTRL_PWR_BIT = 3;
   localparam int CTRL_CH_HI = 1;
   localparam int CTRL_CH_LO = 0;
   // offset calibration fields
   localparam int OFS_CAL_BIT = 7;
   localparam int OFS_SIGN_BIT = 6;
   localparam int OFS_MAG_HI = 5;
   localparam int OFS_MAG_LO = 3;
   // interrupt layout
   localparam int IRQ_DONE_BIT = 0;
   localparam logic [11:0] DONE_VECTOR = 12'h00C;
   localparam int DONE_PRIORITY = 4;
   // reset values
   localparam logic [3:0] PIN_SEL_RESET = 4'h0;
   localparam logic [1:0] CLK_SEL_RESET = 2'h0;
   localparam logic [1:0] CH_RESET = 2'h0;
   localparam logic [2:0] MAG_RESET = 3'h0;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   // conversion clock codes and divider last counts
   localparam logic [1:0] CLK_DIV16 = 2'b00;
   localparam logic [1:0] CLK_DIV4 = 2'b01;
   localparam logic [1:0] CLK_DIV64 = 2'b10;
   localparam logic [1:0] CLK_RING = 2'b11;
   localparam logic [6:0] DIV16_LAST = 7'h0F;
   localparam logic [6:0] DIV4_LAST = 7'h03;
   localparam logic [6:0] DIV64_LAST = 7'h3F;
   localparam logic [3:0] MSB_INDEX = 4'hB;
   localparam logic [11:0] RESULT_MAX = 12'hFFF;
   // shared pin function
   typedef enum logic [1:0] {
      PIN_PORT = 2'b00,
      PIN_TIMER = 2'b01,
      PIN_REF = 2'b10
   } pin_func_t;
   // conversion sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b11,
      ST_FINISH = 2'b10
   } conv_state_t;
endpackage

// ==== verilog/adc_control_regs.sv ====
// Purpose: register file, prescaler and successive approximation sequencer of the converter
// Assumes: mclk 50 MHz, srst synchronous active high, comparator and ring clock asynchronous
// Notes: zero wait state AHB-Lite slave, read data registered in the address phase
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
module adc_control_regs
   import adc_ctrl_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic comparator_in,
   input wire logic ring_osc_in,
   input wire logic timer_clock_input,
   output logic [3:0] analog_enable,
   output logic [1:0] shared_pin_func,
   output logic [1:0] channel_sel,
   output logic ref_network_on,
   output logic sample_hold,
   output logic [11:0] trial_code,
   output logic irq
);
   // bus and register state
   logic wr_pend_q;
   logic [7:0] wr_idx_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic [3:0] pin_sel_q;
   logic ref_sel_q;
   logic [1:0] clk_sel_q;
   logic run_q;
   logic run_d;
   logic pwr_q;
   logic [1:0] ch_q;
   logic [1:0] ch_d;
   logic cal_q;
   logic sign_q;
   logic [2:0] mag_q;
   logic [11:0] result_q;
   logic done_q;
   logic done_d;
   logic irq_en_q;
   logic irq_q;
   pin_func_t pin_func_q;
   // conversion state
   conv_state_t st_q;
   conv_state_t st_d;
   logic [11:0] sar_q;
   logic [11:0] sar_d;
   logic [3:0] idx_q;
   logic [3:0] idx_d;
   logic [6:0] presc_q;
   logic comp_s1_q;
   logic comp_s2_q;
   logic ring_s1_q;
   logic ring_s2_q;
   logic ring_s3_q;
   logic sample_hold_q;

   // address phase decode
   wire addr_ok = hsel && hready && htrans[1];
   wire addr_hit = (haddr[31:10] == 22'h00_0000);
   wire [7:0] rd_idx = haddr[9:2];
   wire [7:0] wd = hwdata[7:0];

   // data phase write strobes
   wire wr_pin = wr_pend_q && (wr_idx_q == IDX_PIN_SEL);
   wire wr_ctrl = wr_pend_q && (wr_idx_q == IDX_CTRL);
   wire wr_ofs = wr_pend_q && (wr_idx_q == IDX_OFFSET);
   wire wr_clr = wr_pend_q && (wr_idx_q == IDX_IRQ_CLEAR);
   wire wr_en = wr_pend_q && (wr_idx_q == IDX_IRQ_ENABLE);

   // register read views
   wire [7:0] v_pin = {4'h0, pin_sel_q};
   wire [7:0] v_ctrl = {ref_sel_q, clk_sel_q, run_q, pwr_q, 1'b0, ch_q};
   wire [7:0] v_ofs = {cal_q, sign_q, mag_q, 3'b000};
   wire [7:0] v_upper = result_q[11:4];
   wire [7:0] v_high = {4'h0, result_q[11:8]};
   wire [7:0] v_low = result_q[7:0];
   wire [7:0] v_stat = {7'h00, done_q};
   wire [7:0] v_en = {7'h00, irq_en_q};

   // read selection, unmapped and clear register read zero
   wire [7:0] rd_byte =
      !addr_hit ? 8'h00 :
      (rd_idx == IDX_PIN_SEL) ? v_pin :
      (rd_idx == IDX_CTRL) ? v_ctrl :
      (rd_idx == IDX_OFFSET) ? v_ofs :
      (rd_idx == IDX_RES_UPPER) ? v_upper :
      (rd_idx == IDX_RES_HIGH) ? v_high :
      (rd_idx == IDX_RES_LOW) ? v_low :
      (rd_idx == IDX_IRQ_STATUS) ? v_stat :
      (rd_idx == IDX_IRQ_ENABLE) ? v_en : 8'h00;
   wire rd_req = addr_ok && !hwrite;

   // bus slave: capture address phase, answer with no wait state
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         wr_pend_q <= addr_ok && hwrite && addr_hit;
         wr_idx_q <= rd_idx;
         hrdata_q <= rd_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // conversion clock: divider tick or rising edge of synced ring clock
   wire [6:0] presc_last =
      (clk_sel_q == CLK_DIV4) ? DIV4_LAST :
      (clk_sel_q == CLK_DIV64) ? DIV64_LAST : DIV16_LAST;
   wire div_tick = (presc_q >= presc_last);
   wire ring_tick = ring_s2_q && !ring_s3_q;
   wire conv_tick = (clk_sel_q == CLK_RING) ? ring_tick : div_tick;

   // prescaler and input synchronisers
   always_ff @(posedge mclk) begin
      if (srst) begin
         presc_q <= 7'h00;
         comp_s1_q <= 1'b0;
         comp_s2_q <= 1'b0;
         ring_s1_q <= 1'b0;
         ring_s2_q <= 1'b0;
         ring_s3_q <= 1'b0;
      end else begin
         presc_q <= div_tick ? 7'h00 : presc_q + 7'h01;
         comp_s1_q <= comparator_in;
         comp_s2_q <= comp_s1_q;
         ring_s1_q <= ring_osc_in;
         ring_s2_q <= ring_s1_q;
         ring_s3_q <= ring_s2_q;
      end
   end

   // offset correction of the raw code, saturating at both ends
   wire [12:0] raw13 = {1'b0, sar_q};
   wire [12:0] ofs13 = {9'h000, mag_q, 1'b0};
   wire [12:0] sum13 = raw13 + ofs13;
   wire under = raw13 < ofs13;
   wire [11:0] pos_res = sum13[12] ? RESULT_MAX : sum13[11:0];
   wire [11:0] neg_res = under ? 12'h000 : sar_q - ofs13[11:0];
   wire [11:0] cal_res = sign_q ? pos_res : neg_res;
   wire [11:0] final_res = cal_q ? cal_res : sar_q;

   // sequencer helpers
   wire [11:0] bit_mask = 12'h001 << idx_q;
   wire finish = (st_q == ST_FINISH);
   wire run_set = wr_ctrl && wd[CTRL_RUN_BIT];

   // successive approximation sequencer
   always_comb begin
      st_d = st_q;
      sar_d = sar_q;
      idx_d = idx_q;
      case (st_q)
         ST_IDLE: begin
            if (run_q && pwr_q) begin
               st_d = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (!pwr_q) begin
               st_d = ST_IDLE;
            end else if (conv_tick) begin
               st_d = ST_CONVERT;
               sar_d = 12'h800;
               idx_d = MSB_INDEX;
            end
         end
         ST_CONVERT: begin
            if (!pwr_q) begin
               st_d = ST_IDLE;
            end else if (conv_tick) begin
               // keep the trial bit when the input is at or above the trial level
               sar_d = comp_s2_q ? sar_q : (sar_q & ~bit_mask);
               if (idx_q == 4'h0) begin
                  st_d = ST_FINISH;
               end else begin
                  sar_d = sar_d | (bit_mask >> 1);
                  idx_d = idx_q - 4'h1;
               end
            end
         end
         ST_FINISH: begin
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // run bit: set by software, cleared only at completion, set wins
   assign run_d = run_set ? 1'b1 : (finish ? 1'b0 : run_q);
   // done flag: set at completion, cleared by write of one, set wins
   assign done_d = finish ? 1'b1 :
      ((wr_clr && wd[IRQ_DONE_BIT]) ? 1'b0 : done_q);
   // channel field accepted only while idle and no pending flag
   assign ch_d = (wr_ctrl && !done_q && !run_q) ? wd[CTRL_CH_HI:CTRL_CH_LO] : ch_q;

   // sequencer state registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= ST_IDLE;
         sar_q <= RESULT_RESET;
         idx_q <= 4'h0;
         sample_hold_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sar_q <= sar_d;
         idx_q <= idx_d;
         sample_hold_q <= (st_d == ST_SAMPLE); // registered copy of the sample state
      end
   end

   // software registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_sel_q <= PIN_SEL_RESET;
         ref_sel_q <= 1'b0;
         clk_sel_q <= CLK_SEL_RESET;
         pwr_q <= 1'b0;
         cal_q <= 1'b0;
         sign_q <= 1'b0;
         mag_q <= MAG_RESET;
         irq_en_q <= 1'b0;
      end else begin
         if (wr_pin) begin
            pin_sel_q <= wd[3:0];
         end
         if (wr_ctrl) begin
            ref_sel_q <= wd[CTRL_REF_BIT];
            clk_sel_q <= wd[CTRL_CLK_HI:CTRL_CLK_LO];
            pwr_q <= wd[CTRL_PWR_BIT];
         end
         if (wr_ofs) begin
            cal_q <= wd[OFS_CAL_BIT];
            sign_q <= wd[OFS_SIGN_BIT];
            mag_q <= wd[OFS_MAG_HI:OFS_MAG_LO];
         end
         if (wr_en) begin
            irq_en_q <= wd[IRQ_DONE_BIT];
         end
      end
   end

   // hardware updated state and pin controls
   always_ff @(posedge mclk) begin
      if (srst) begin
         run_q <= 1'b0;
         done_q <= 1'b0;
         ch_q <= CH_RESET;
         result_q <= RESULT_RESET;
         irq_q <= 1'b0;
         pin_func_q <= PIN_PORT;
      end else begin
         run_q <= run_d;
         done_q <= done_d;
         ch_q <= ch_d;
         if (finish) begin
            result_q <= final_res;
         end
         irq_q <= done_q && irq_en_q;
         pin_func_q <= ref_sel_q ? PIN_REF :
            (timer_clock_input ? PIN_TIMER : PIN_PORT);
      end
   end

   // outputs straight from flip-flops
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign hrdata = hrdata_q;
   assign analog_enable = pin_sel_q;
   assign shared_pin_func = pin_func_q;
   assign channel_sel = ch_q;
   assign ref_network_on = pwr_q;
   assign sample_hold = sample_hold_q;
   assign trial_code = sar_q;
   assign irq = irq_q;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   property p_pin_write;
      wr_pin |=> (analog_enable == $past(wd[3:0]));
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("pin select not applied");

   property p_ref_prio;
      ref_sel_q |=> (shared_pin_func == PIN_REF);
   endproperty
   a_ref_prio: assert property (p_ref_prio) else $error("reference not on shared pin");

   property p_timer_prio;
      (!ref_sel_q && timer_clock_input) |=> (shared_pin_func == PIN_TIMER);
   endproperty
   a_timer_prio: assert property (p_timer_prio) else $error("timer priority wrong");

   property p_div4_tick;
      (clk_sel_q == CLK_DIV4 && div_tick) ##1 (clk_sel_q == CLK_DIV4) [*4] |-> div_tick;
   endproperty
   a_div4_tick: assert property (p_div4_tick) else $error("divide by four wrong");

   property p_run_hold;
      (run_q && !finish) |=> run_q;
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("run cleared early");

   property p_unpowered_abort;
      (!pwr_q && st_q != ST_FINISH) |=> (st_q == ST_IDLE);
   endproperty
   a_unpowered_abort: assert property (p_unpowered_abort) else $error("ran unpowered");

   property p_chan_gate;
      (wr_ctrl && (done_q || run_q)) |=> $stable(channel_sel);
   endproperty
   a_chan_gate: assert property (p_chan_gate) else $error("channel changed while busy");

   property p_finish_update;
      (finish && !run_set) |=> (!run_q && done_q && result_q == $past(final_res));
   endproperty
   a_finish_update: assert property (p_finish_update) else $error("completion update");

   property p_cal_off;
      (finish && !cal_q) |=> (result_q == $past(sar_q));
   endproperty
   a_cal_off: assert property (p_cal_off) else $error("offset applied while off");

   property p_ofs_read;
      (rd_req && addr_hit && rd_idx == IDX_OFFSET) |=> (hrdata[2:0] == 3'b000);
   endproperty
   a_ofs_read: assert property (p_ofs_read) else $error("offset low bits nonzero");

   property p_sar_end;
      (st_q == ST_CONVERT && conv_tick && pwr_q && idx_q == 4'h0) |=> finish;
   endproperty
   a_sar_end: assert property (p_sar_end) else $error("sequence length wrong");

   property p_irq;
      (done_q && irq_en_q) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   c_finish: cover property (finish ##2 irq);
   c_chan_refused: cover property (wr_ctrl && run_q);
   c_cal_pos: cover property (finish && cal_q && sign_q);
endmodule

// ==== verif/sar_far_model.sv ====
// Purpose: analog side model: input multiplexer, comparator and ring oscillator
// Assumes: levels of the four inputs are fixed by parameter, 12 bits each
// Notes: an unpowered reference makes the comparator toggle every cycle
`timescale 1ns/1ns
module sar_far_model #(
   parameter logic [47:0] LV = 48'h0000_0000_0000
) (
   input wire logic mclk,
   input wire logic [1:0] channel_sel,
   input wire logic [11:0] trial_code,
   input wire logic ref_network_on,
   output logic comparator_in,
   output logic ring_osc_in
);
   logic [11:0] level;
   logic junk_q = 1'b0;
   // mux picks the selected input level
   assign level = LV[channel_sel * 12 +: 12];
   // toggling pattern stands in for a dead reference
   always_ff @(posedge mclk) begin
      junk_q <= ~junk_q;
   end
   // comparator high while input at or above the trial level
   assign comparator_in = ref_network_on ? (level >= trial_code) : junk_q;
   // free running ring oscillator, 20 system cycles a period
   initial begin
      ring_osc_in = 1'b0;
      forever #200 ring_osc_in = ~ring_osc_in;
   end
endmodule

// ==== verif/tb_top.sv ====
// Purpose: register level test of the converter control block
// Assumes: single AHB-Lite master, hready fed back from hreadyout
// Notes: expected results come from the input levels given to the model
`timescale 1ns/1ns
module tb_top
   import adc_ctrl_pkg::*;
;
   localparam logic [47:0] LV = 48'h007A_5C0F_05A3;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic timer = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, ref_on, irq, comp, ring;
   logic [31:0] hrdata;
   logic [3:0] aen;
   logic [1:0] spf, chs;
   logic [11:0] trial;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int sh_n = 0;
   int sh_mark = 0;
   logic sh;
   logic [31:0] d;
   logic [7:0] ri [6] = '{IDX_PIN_SEL, IDX_CTRL, IDX_OFFSET, IDX_IRQ_STATUS, IDX_IRQ_ENABLE, 8'h3F};

   // clock and run limit
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      // count cycles spent sampling
      if (sh === 1'b1) begin
         sh_n++;
      end
      if (cyc == 30000) begin
         fail_count++;
         stop_test();
      end
   end

   adc_control_regs dut_u (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comparator_in(comp),
      .ring_osc_in(ring), .timer_clock_input(timer), .analog_enable(aen),
      .shared_pin_func(spf), .channel_sel(chs), .ref_network_on(ref_on), .sample_hold(sh),
      .trial_code(trial), .irq(irq));

   sar_far_model #(.LV(LV)) far_u (.mclk(mclk), .channel_sel(chs), .trial_code(trial),
      .ref_network_on(ref_on), .comparator_in(comp), .ring_osc_in(ring));

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // one single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, idx, wd, x);
   endtask

   task automatic rd(input logic [7:0] idx);
      bus(1'b0, idx, 32'h0000_0000, d);
   endtask

   // full conversion: start, ignored stop, completion, results, interrupt
   task automatic conv(input logic [1:0] ck, input logic [1:0] ch, input logic [11:0] e,
      input logic ie);
      int n;
      sh_mark = sh_n;
      wr(IDX_CTRL, {24'h0, 1'b0, ck, 2'b01, 1'b0, ch});
      wr(IDX_CTRL, {24'h0, 1'b0, ck, 2'b11, 1'b0, ch});
      wr(IDX_CTRL, {24'h0, 1'b0, ck, 2'b01, 1'b0, ch});
      rd(IDX_CTRL);
      chk(d & 32'h0000_0010, 32'h0000_0010);
      n = 0;
      d = 32'h0000_0000;
      while (d[0] !== 1'b1 && n < 600) begin
         rd(IDX_IRQ_STATUS);
         n++;
      end
      chk(d, 32'h0000_0001);
      chk({31'h0, sh_n > sh_mark}, 32'h0000_0001);
      rd(IDX_RES_UPPER);
      chk(d, {24'h0, e[11:4]});
      rd(IDX_RES_HIGH);
      chk(d, {28'h0, e[11:8]});
      rd(IDX_RES_LOW);
      chk(d, {24'h0, e[7:0]});
      rd(IDX_CTRL);
      chk(d & 32'h0000_0010, 32'h0000_0000);
      wr(IDX_CTRL, {24'h0, 1'b0, ck, 2'b01, 1'b0, ~ch});
      // let the data phase update land before looking at the pins
      @(posedge mclk);
      chk({30'h0, chs}, {30'h0, ch});
      chk({31'h0, irq}, {31'h0, ie});
      wr(IDX_IRQ_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(IDX_IRQ_STATUS);
      chk(d, 32'h0000_0000);
   endtask

   // main sequence
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk({30'h0, hresp, hreadyout}, 32'h0000_0001);
      foreach (ri[i]) begin
         rd(ri[i]);
         chk(d, 32'h0000_0000);
      end
      wr(IDX_PIN_SEL, 32'h0000_000A);
      rd(IDX_PIN_SEL);
      chk(d, 32'h0000_000A);
      chk({28'h0, aen}, 32'h0000_000A);
      wr(IDX_OFFSET, 32'h0000_00FF);
      rd(IDX_OFFSET);
      chk(d, 32'h0000_00F8);
      wr(IDX_OFFSET, 32'h0000_0000);
      timer <= 1'b1;
      wr(IDX_CTRL, 32'h0000_0080);
      repeat (2) @(posedge mclk);
      chk({30'h0, spf}, {30'h0, PIN_REF});
      wr(IDX_CTRL, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      chk({30'h0, spf}, {30'h0, PIN_TIMER});
      timer <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({30'h0, spf}, {30'h0, PIN_PORT});
      wr(IDX_IRQ_ENABLE, 32'h0000_0001);
      // run request without power must wait
      wr(IDX_CTRL, 32'h0000_0030);
      sh_mark = sh_n;
      repeat (200) @(posedge mclk);
      chk(sh_n, sh_mark);
      rd(IDX_IRQ_STATUS);
      chk(d, 32'h0000_0000);
      rd(IDX_CTRL);
      chk(d & 32'h0000_0010, 32'h0000_0010);
      chk({31'h0, ref_on}, 32'h0000_0000);
      conv(CLK_DIV4, 2'b00, LV[11:0], 1'b1);
      chk({31'h0, ref_on}, 32'h0000_0001);
      conv(CLK_DIV16, 2'b01, LV[23:12], 1'b1);
      conv(CLK_DIV64, 2'b10, LV[35:24], 1'b1);
      conv(CLK_RING, 2'b11, LV[47:36], 1'b1);
      // offset correction: add, subtract, saturate at zero, masked interrupt
      wr(IDX_OFFSET, 32'h0000_00D8);
      conv(CLK_DIV4, 2'b00, LV[11:0] + 12'h006, 1'b1);
      wr(IDX_OFFSET, 32'h0000_0098);
      conv(CLK_DIV4, 2'b00, LV[11:0] - 12'h006, 1'b1);
      wr(IDX_OFFSET, 32'h0000_00B8);
      wr(IDX_IRQ_ENABLE, 32'h0000_0000);
      conv(CLK_DIV4, 2'b11, 12'h000, 1'b0);
      stop_test();
   end
endmodule
